// file: logic/tcomp_ctrl.sv
/*
 Temperature compensation control: AHB-Lite register slave, sensing
 enables, battery-mode conversion scheduler and trim selection.
 Assumes the analog converter returns raw samples on ADC_DATA_I with a
 done pulse, and that final trim values arrive from a computation block.
*/
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tcomp_cfg.svh"
module tcomp_ctrl #(
	parameter logic [63:0] CONV_CYCLES = `CONV_CYC,
	parameter logic [63:0] SHORT_CYCLES = `SHORT_PERIOD_CYC,
	parameter logic [63:0] LONG_CYCLES = `LONG_PERIOD_CYC
) (
	input wire logic MCLK_I,
	input wire logic RESETN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic ON_BATTERY_I,
	input wire logic VBAT_LOW_I,
	input wire logic [9:0] ADC_DATA_I,
	input wire logic ADC_DONE_I,
	input wire tcomp_pkg::trim_t CALC_TRIM_I,
	output logic SENSOR_ON_O,
	output logic ADC_START_O,
	output logic TRIM_UPDATE_O,
	output tcomp_pkg::trim_t OSC_TRIM_O,
	output logic [7:0] COLD_COEF_O,
	output logic [4:0] GAIN_O
);
	import tcomp_pkg::*;

	logic bat_s1_q, bat_q, low_s1_q, low_q;
	logic [7:0] cold_coef_q, init_trim_q;
	logic [7:0] sense_gain_q;
	logic wr_q;
	logic [7:0] addr_q;
	logic tse_prev_q;
	conv_state_t state_q;
	logic [63:0] conv_cnt_q, period_cnt_q;
	logic [10:0] sum_q;
	logic [9:0] temp_q;
	trim_t final_q;
	logic [31:0] rdata_q;
	logic [63:0] period_len;
	logic temp_sense_enable, battery_comp_enable_eff, start_req, sensing_allowed, take;

	// Pins from other domains are synchronised twice
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			bat_s1_q <= 1'b0;
			bat_q <= 1'b0;
			low_s1_q <= 1'b0;
			low_q <= 1'b0;
		end else begin
			bat_s1_q <= ON_BATTERY_I;
			bat_q <= bat_s1_q;
			low_s1_q <= VBAT_LOW_I;
			low_q <= low_s1_q;
		end
	end

	// Address phase capture, always zero wait states
	assign take = HSEL_I && HREADY_I && HTRANS_I[1];
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q <= take && HWRITE_I;
			addr_q <= HADDR_I[9:2];
		end
	end
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;

	// Cold coefficient with preset, host writable
	// Stored as scaled magnitude, no conversion here
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			cold_coef_q <= `COLD_COEF_PRESET;
		end else if (wr_q && addr_q == `COLD_COEF_ADDR) begin
			cold_coef_q <= HWDATA_I[7:0];
		end
	end

	// Control and gain; enables reset to zero
	// Battery enable and rate default zero
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			sense_gain_q <= {3'h0, `GAIN_PRESET};
		end else if (wr_q && addr_q == `SENSE_GAIN_ADDR) begin
			sense_gain_q <= HWDATA_I[7:0];
		end
	end

	// Initial trim; analog code zero means +32 ppm
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			init_trim_q <= `INIT_TRIM_PRESET;
		end else if (wr_q && addr_q == `INIT_TRIM_ADDR) begin
			init_trim_q <= HWDATA_I[7:0];
		end
	end

	assign temp_sense_enable = sense_gain_q[`TSE_BIT];
	assign battery_comp_enable_eff = sense_gain_q[`BATTERY_COMP_ENABLE_BIT] && !low_q;
	// Main supply needs only the sense enable
	assign sensing_allowed = temp_sense_enable && (!bat_q || battery_comp_enable_eff);
	assign period_len = sense_gain_q[`BATTERY_COMP_RATE_BIT] ? SHORT_CYCLES : LONG_CYCLES;

	// Battery period timer runs only with battery enable
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			period_cnt_q <= 64'h0;
		end else if (!(bat_q && battery_comp_enable_eff && temp_sense_enable) || period_cnt_q >= period_len - 64'h1) begin
			period_cnt_q <= 64'h0;
		end else begin
			period_cnt_q <= period_cnt_q + 64'h1;
		end
	end

	// Rising sense enable or battery period starts a cycle
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			tse_prev_q <= 1'b0;
		end else begin
			tse_prev_q <= temp_sense_enable;
		end
	end
	assign start_req = sensing_allowed && ((temp_sense_enable && !tse_prev_q) ||
		(bat_q && period_cnt_q == period_len - 64'h1));

	// Two conversions then average; one window length
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			state_q <= ST_IDLE;
			conv_cnt_q <= 64'h0;
			sum_q <= 11'h000;
			temp_q <= 10'h000;
		end else if (!sensing_allowed) begin
			state_q <= ST_IDLE;
			conv_cnt_q <= 64'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_req) begin
						state_q <= ST_CONV1;
						conv_cnt_q <= 64'h0;
						sum_q <= 11'h000;
					end
				end
				ST_CONV1, ST_CONV2: begin
					conv_cnt_q <= conv_cnt_q + 64'h1;
					// Window ends on done pulse or timeout, whichever first
					if (ADC_DONE_I || conv_cnt_q >= CONV_CYCLES - 64'h1) begin
						sum_q <= sum_q + {1'b0, ADC_DATA_I};
						conv_cnt_q <= 64'h0;
						state_q <= (state_q == ST_CONV1) ? ST_CONV2 : ST_STORE;
					end
				end
				ST_STORE: begin
					temp_q <= sum_q[10:1];
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	assign ADC_START_O = (state_q == ST_CONV1 || state_q == ST_CONV2) && conv_cnt_q == 64'h0;
	assign SENSOR_ON_O = state_q != ST_IDLE;
	assign TRIM_UPDATE_O = state_q == ST_STORE;

	// Final trims change only at the end of a cycle
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			final_q <= '0;
		end else if (state_q == ST_STORE && sensing_allowed) begin
			final_q <= CALC_TRIM_I;
		end
	end

	// Sensing off selects the initial trims
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			OSC_TRIM_O <= '0;
			COLD_COEF_O <= 8'h00;
			GAIN_O <= 5'h00;
		end else begin
			OSC_TRIM_O <= temp_sense_enable ? final_q :
				'{analog: init_trim_q[5:0], digital: {3'h0, init_trim_q[7:6]}};
			COLD_COEF_O <= cold_coef_q;
			GAIN_O <= sense_gain_q[`GAIN_MSB:0];
		end
	end

	// Read mux; unmapped words read zero
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			rdata_q <= 32'h0;
		end else if (take && !HWRITE_I) begin
			case (HADDR_I[9:2])
				`COLD_COEF_ADDR: rdata_q <= {24'h0, cold_coef_q};
				`SENSE_GAIN_ADDR: rdata_q <= {24'h0, sense_gain_q};
				`INIT_TRIM_ADDR: rdata_q <= {24'h0, init_trim_q};
				`FINAL_AT_ADDR: rdata_q <= {26'h0, final_q.analog};
				`FINAL_DT_ADDR: rdata_q <= {27'h0, final_q.digital};
				`TEMP_ADDR: rdata_q <= {22'h0, temp_q};
				default: rdata_q <= 32'h0;
			endcase
		end
	end
	assign HRDATA_O = rdata_q;
endmodule

// file: shared/tcomp_cfg.svh
/*
 Offsets, field positions, reset values and timing counts for the
 temperature compensation control block. Assumes a 200 MHz MCLK_I.
*/
// Functional notes
// - Hold cold curvature coefficient as an eight-bit unsigned register.
// - Coefficient is magnitude in ppm per degree squared times 2048.
// - Power-up loads a factory preset; host may overwrite it later.
// - Bit 7 of gain register enables sensing, conversion, final trim update.
// - Sensing enable resets to zero, disabled.
// - Sensing disabled: oscillator trim comes from initial trim values.
// - Enable set starts cycle of two conversions, average stored.
// - Bit 6 enables battery-mode sensing; zero means none on battery.
// - Battery below threshold forces battery compensation off.
// - Bit 5 picks battery period: zero ten minutes, one one minute.
// - Period select matters only while battery compensation enabled.
// - Conversion window is the same length on battery and main supply.
// - Initial analog trim code zero is +32 ppm, each step one lower.
`ifndef TCOMP_CFG_SVH
`define TCOMP_CFG_SVH
`define COLD_COEF_ADDR 8'h0C
`define SENSE_GAIN_ADDR 8'h0D
`define INIT_TRIM_ADDR 8'h0B
`define FINAL_AT_ADDR 8'h0E
`define FINAL_DT_ADDR 8'h0F
`define TEMP_ADDR 8'h28
`define COEF_SCALE 2048
`define TSE_BIT 7
`define BATTERY_COMP_ENABLE_BIT 6
`define BATTERY_COMP_RATE_BIT 5
`define GAIN_MSB 4
`define COLD_COEF_PRESET 8'h46
`define GAIN_PRESET 5'h00
`define INIT_TRIM_PRESET 8'h20
`define CLK_HZ 200000000
`define CONV_MS 22
`define CONV_CYC ((`CONV_MS * 64'd200000000) / 64'd1000)
`define SHORT_PERIOD_S 60
`define LONG_PERIOD_S 600
`define SHORT_PERIOD_CYC (`SHORT_PERIOD_S * 64'd200000000)
`define LONG_PERIOD_CYC (`LONG_PERIOD_S * 64'd200000000)
`endif

// file: shared/tcomp_pkg.sv
/*
 Types for the temperature compensation control block.
 Assumes the constants header is included alongside.
*/
package tcomp_pkg;
	typedef struct packed {
		logic [5:0] analog;
		logic [4:0] digital;
	} trim_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CONV1 = 4'b0010,
		ST_CONV2 = 4'b0100,
		ST_STORE = 4'b1000
	} conv_state_t;
endpackage

// file: dv/tcomp_adc_model.sv
/* Converter model: answers each start with a sample.
 Assumes start is a one-cycle pulse on the rising edge. */
`timescale 1ns/1ps
module tcomp_adc_model (
	input wire logic clk_i,
	input wire logic start_i,
	output logic done_o,
	output logic [9:0] data_o,
	output tcomp_pkg::trim_t trim_o
);
	int cnt = 0;
	logic odd = 1'b0;
	assign trim_o = {6'h15, 5'h03};
	initial begin
		done_o = 1'b0;
		data_o = 10'h000;
	end
	always @(posedge clk_i) begin
		done_o <= (cnt == 1);
		// Data only valid with done; scrambled otherwise
		data_o <= (cnt == 1) ? (odd ? 10'h102 : 10'h100) : ~data_o;
		if (cnt == 1) odd <= ~odd;
		if (start_i) cnt <= 5;
		else if (cnt != 0) cnt <= cnt - 1;
	end
endmodule

// file: dv/tcomp_ctrl_monitor.sv
/* Port checker for tcomp_ctrl.
 Bound to every tcomp_ctrl instance. */
`timescale 1ns/1ps
module tcomp_ctrl_monitor (
	input wire logic MCLK_I, RESETN_I, HSEL_I, HWRITE_I, HREADY_I, ON_BATTERY_I,
	input wire logic VBAT_LOW_I, SENSOR_ON_O, ADC_START_O, TRIM_UPDATE_O,
	input wire logic [31:0] HADDR_I, HWDATA_I, HRDATA_O,
	input wire logic [1:0] HTRANS_I,
	input wire tcomp_pkg::trim_t CALC_TRIM_I, OSC_TRIM_O,
	input wire logic [7:0] COLD_COEF_O,
	input wire logic [4:0] GAIN_O
);
	import tcomp_pkg::*;
	logic wc_q, wg_q, rc_q;
	logic [1:0] n_q;
	wire logic aph = RESETN_I && HSEL_I && HREADY_I && HTRANS_I[1];
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);
	// Data-phase markers
	always_ff @(posedge MCLK_I) begin
		wc_q <= aph && HWRITE_I && HADDR_I[9:2] == 8'h0C;
		wg_q <= aph && HWRITE_I && HADDR_I[9:2] == 8'h0D;
		rc_q <= aph && !HWRITE_I && HADDR_I[9:2] == 8'h0C;
	end
	// Starts per cycle; cleared when idle so an abort cannot leak
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I || TRIM_UPDATE_O || !(SENSOR_ON_O || ADC_START_O)) n_q <= 2'h0;
		else if (ADC_START_O) n_q <= n_q + 2'h1;
	end
	property p_rd; rc_q |-> HRDATA_O == {24'h0, COLD_COEF_O}; endproperty
	a_rd: assert property (p_rd) else $error("read data bad");
	// Register lands at the data-phase edge, the output copy one edge later
	property p_coef; wc_q |=> ##1 COLD_COEF_O == $past(HWDATA_I[7:0], 2); endproperty
	a_coef: assert property (p_coef) else $error("coef bad");
	property p_gain; wg_q |=> ##1 GAIN_O == $past(HWDATA_I[4:0], 2); endproperty
	a_gain: assert property (p_gain) else $error("gain bad");
	property p_pulse; ADC_START_O |=> !ADC_START_O; endproperty
	a_pulse: assert property (p_pulse) else $error("start long");
	property p_two; TRIM_UPDATE_O |-> n_q == 2'h2; endproperty
	a_two: assert property (p_two) else $error("not two");
	property p_upd; TRIM_UPDATE_O |-> ##[1:2] OSC_TRIM_O == CALC_TRIM_I; endproperty
	a_upd: assert property (p_upd) else $error("final trim bad");
	property p_hold; SENSOR_ON_O [*3] ##0 !TRIM_UPDATE_O |=> $stable(OSC_TRIM_O); endproperty
	a_hold: assert property (p_hold) else $error("trim moved");
	property p_bat; (ON_BATTERY_I && VBAT_LOW_I) [*4] |-> !ADC_START_O; endproperty
	a_bat: assert property (p_bat) else $error("low battery start");
	c_upd: cover property (TRIM_UPDATE_O);
	c_bat: cover property (ON_BATTERY_I && ADC_START_O);
	c_rd: cover property (rc_q);
endmodule
bind tcomp_ctrl tcomp_ctrl_monitor mon (.*);

// file: dv/tcomp_ctrl_tb.sv
/* Self-checking bench for tcomp_ctrl over AHB-Lite.
 Assumes the converter model and the bound checker. */
`timescale 1ns/1ps
module tcomp_ctrl_tb;
	import tcomp_pkg::*;
	logic MCLK_I, RESETN_I, HSEL_I, HWRITE_I, HREADY_I, HREADYOUT_O, HRESP_O, ADC_DONE_I;
	logic ON_BATTERY_I, VBAT_LOW_I, SENSOR_ON_O, ADC_START_O, TRIM_UPDATE_O;
	logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, r;
	logic [1:0] HTRANS_I;
	logic [2:0] HSIZE_I;
	logic [9:0] ADC_DATA_I;
	logic [7:0] COLD_COEF_O;
	logic [4:0] GAIN_O;
	trim_t CALC_TRIM_I, OSC_TRIM_O;
	int failures = 0, total_checks = 0, cyc = 0, nu = 0;
	assign HREADY_I = HREADYOUT_O;
	tcomp_ctrl #(.CONV_CYCLES(64'd20), .SHORT_CYCLES(64'd200), .LONG_CYCLES(64'd500)) dut (.*);
	tcomp_adc_model adc (.clk_i(MCLK_I), .start_i(ADC_START_O), .done_o(ADC_DONE_I),
		.data_o(ADC_DATA_I), .trim_o(CALC_TRIM_I));
	initial begin
		MCLK_I = 1'b0;
		forever #2.5 MCLK_I = ~MCLK_I;
	end
	// Update counter and hang guard
	always @(posedge MCLK_I) begin
		cyc <= cyc + 1;
		if (TRIM_UPDATE_O === 1'b1) nu <= nu + 1;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic ck(input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	// One single transfer; waits for hready in both phases
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		HTRANS_I <= 2'h2;
		HADDR_I <= {22'h0, a, 2'h0};
		HWRITE_I <= w;
		do @(posedge MCLK_I); while (HREADYOUT_O !== 1'b1);
		HTRANS_I <= 2'h0;
		HWDATA_I <= d;
		do @(posedge MCLK_I); while (HREADYOUT_O !== 1'b1);
		r = HRDATA_O;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		ck(r, e);
	endtask
	task automatic wu();
		int n0 = nu;
		for (int i = 0; i < 1000 && nu == n0; i++) @(posedge MCLK_I);
		repeat (3) @(posedge MCLK_I);
	endtask
	task automatic win(input int lo, hi);
		int n0 = nu;
		repeat (1000) @(posedge MCLK_I);
		ck(32'(nu - n0 >= lo && nu - n0 <= hi), 32'h1);
	endtask
	initial begin
		{RESETN_I, HSEL_I, HWRITE_I, ON_BATTERY_I, VBAT_LOW_I} = 5'h0;
		{HTRANS_I, HADDR_I, HWDATA_I} = 66'h0;
		HSIZE_I = 3'h2;
		repeat (16) @(posedge MCLK_I);
		RESETN_I <= 1'b1;
		HSEL_I <= 1'b1;
		repeat (2) @(posedge MCLK_I);
		rd(8'h0C, 32'h46);
		ck(HRESP_O, 32'h0);
		rd(8'h0D, 32'h0);
		ck(OSC_TRIM_O.analog, 6'h20);
		xf(1'b1, 8'h0C, (2048 * 60 + 500) / 1000);
		rd(8'h0C, 32'h7B);
		xf(1'b1, 8'h0B, 32'h3F);
		repeat (2) @(posedge MCLK_I);
		ck(OSC_TRIM_O.analog, 6'h3F);
		xf(1'b1, 8'h0D, 32'h1F);
		xf(1'b1, 8'h0D, 32'h9F);
		wu();
		ck(OSC_TRIM_O, {6'h15, 5'h03});
		ck(GAIN_O, 5'h1F);
		rd(8'h28, 32'h101);
		xf(1'b1, 8'h0E, 32'h0);
		rd(8'h0E, 32'h15);
		rd(8'h10, 32'h0);
		ON_BATTERY_I <= 1'b1;
		xf(1'b1, 8'h0D, 32'hFF);
		win(4, 5);
		xf(1'b1, 8'h0D, 32'hDF);
		win(1, 2);
		wu();
		VBAT_LOW_I <= 1'b1;
		win(0, 0);
		xf(1'b1, 8'h0D, 32'hBF);
		VBAT_LOW_I <= 1'b0;
		win(0, 0);
		wrap_up();
	end
endmodule
